/* File: rtl/host_port_ctrl_regs.vh */
// register map, field positions, reset values and codes of the host port control block
`ifndef HOST_PORT_CTRL_REGS_VH
`define HOST_PORT_CTRL_REGS_VH

`define ADDR_W 8
`define OFS_STROBE_IRQ_POLARITY 8'h00
`define OFS_SUSPEND_MANAGEMENT 8'h04
`define OFS_STROBE_IRQ_ENABLE 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_PORT_STATUS 8'h14

`define POL_INVERT_BIT 2
`define SUS_IGNORE_BIT 0
`define SUS_GRACEFUL_BIT 1
`define EN_STROBE_BIT 2

`define REG16_RESET 16'h0000
`define POL_WR_MASK 16'h0004
`define SUS_WR_MASK 16'h0003

// interrupt status / mask layout
`define IRQ_W 3
`define IRQ_CPU_BIT 0
`define IRQ_HALTED_BIT 1
`define IRQ_RESUMED_BIT 2
`define IRQ_RESET 3'h0

// port status layout
`define PST_HALTED_BIT 0
`define PST_READY_BIT 1
`define PST_STROBE_BIT 2
`define PST_SUSPEND_BIT 3
`define PST_MUX8_BIT 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/host_port_suspend_irq_ctrl.v */
// host port strobe interrupt polarity, suspend policy and ready flag, AXI4-Lite slave
`include "host_port_ctrl_regs.vh"
module host_port_suspend_irq_ctrl (
   // clock and reset
   input wire clock,
   input wire rstn,
   // axi4-lite write address
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // host pins and port state
   input wire strobe_pin_n,
   input wire mux8_mode,
   input wire host_to_cpu_irq_bit,
   input wire write_fifo_room,
   input wire ready_pin,
   // emulation suspend and activity
   input wire emu_suspend,
   input wire host_busy,
   input wire dma_busy,
   // outputs
   output wire cpu_irq_req,
   output wire dma_halt,
   output wire host_ready_flag,
   output wire irq
);
   reg [15:0] polarity_q;
   reg [15:0] suspend_q;
   reg [15:0] enable_q;
   reg [`IRQ_W-1:0] status_q;
   reg [`IRQ_W-1:0] status_d;
   reg [`IRQ_W-1:0] mask_q;
   reg cpu_req_q;
   reg strobe_q;
   reg hbit_q;
   reg ready_flag_q;
   reg aw_got_q;
   reg w_got_q;
   reg [`ADDR_W-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_ok;

   wire strobe_s;
   wire suspend_s;
   wire hbit_s;
   wire fifo_room_s;
   wire ready_pin_s;
   wire strobe_active;
   wire hbit_rise;
   wire strobe_rise;
   wire halt_event;
   wire resume_event;
   wire wr_fire;
   wire rd_fire;
   wire [31:0] wr_bits;

   // all pins from the host side pass two flip-flops first
   sync2 u_sync_strobe (
      .clock(clock),
      .rstn(rstn),
      .async_in(strobe_pin_n),
      .sync_out(strobe_s)
   );
   sync2 u_sync_suspend (
      .clock(clock),
      .rstn(rstn),
      .async_in(emu_suspend),
      .sync_out(suspend_s)
   );
   sync2 u_sync_hbit (
      .clock(clock),
      .rstn(rstn),
      .async_in(host_to_cpu_irq_bit),
      .sync_out(hbit_s)
   );
   sync2 u_sync_room (
      .clock(clock),
      .rstn(rstn),
      .async_in(write_fifo_room),
      .sync_out(fifo_room_s)
   );
   sync2 u_sync_rdy (
      .clock(clock),
      .rstn(rstn),
      .async_in(ready_pin),
      .sync_out(ready_pin_s)
   );

   // strobe request level: pin low without invert, pin high with invert
   assign strobe_active = mux8_mode & enable_q[`EN_STROBE_BIT] &
                          (polarity_q[`POL_INVERT_BIT] ? strobe_s : ~strobe_s);
   assign strobe_rise = strobe_active & ~strobe_q;
   assign hbit_rise = hbit_s & ~hbit_q;

   suspend_ctrl u_suspend (
      .clock(clock),
      .rstn(rstn),
      .ignore_suspend(suspend_q[`SUS_IGNORE_BIT]),
      .graceful_halt(suspend_q[`SUS_GRACEFUL_BIT]),
      .suspend_req(suspend_s),
      .host_busy(host_busy),
      .dma_busy(dma_busy),
      .dma_halt(dma_halt),
      .halt_event(halt_event),
      .resume_event(resume_event)
   );

   // one cpu request line, shared by strobe and host interrupt bit
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strobe_q <= 1'b0;
         hbit_q <= 1'b0;
         cpu_req_q <= 1'b0;
         ready_flag_q <= 1'b0;
      end else begin
         strobe_q <= strobe_active;
         hbit_q <= hbit_s;
         cpu_req_q <= strobe_rise | hbit_rise;
         // flag follows fifo room, not the ready pin, so they may differ
         ready_flag_q <= fifo_room_s;
      end
   end

   assign cpu_irq_req = cpu_req_q;
   assign host_ready_flag = ready_flag_q;

   // ---- axi4-lite write side: address and data accepted in either order
   assign s_axi_awready = ~aw_got_q & ~bvalid_q;
   assign s_axi_wready = ~w_got_q & ~bvalid_q;
   assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
   assign wr_bits = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                               {8{wstrb_q[0]}}};

   always @* begin
      case (awaddr_q)
         `OFS_STROBE_IRQ_POLARITY: wr_ok = 1'b1;
         `OFS_SUSPEND_MANAGEMENT: wr_ok = 1'b1;
         `OFS_STROBE_IRQ_ENABLE: wr_ok = 1'b1;
         `OFS_IRQ_STATUS: wr_ok = 1'b1;
         `OFS_IRQ_MASK: wr_ok = 1'b1;
         `OFS_PORT_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // sticky events; a new event in the clearing cycle wins
   always @* begin
      status_d = status_q;
      if (wr_fire && awaddr_q == `OFS_IRQ_STATUS) begin
         status_d = status_q & ~wr_bits[`IRQ_W-1:0];
      end
      status_d[`IRQ_CPU_BIT] = status_d[`IRQ_CPU_BIT] | strobe_rise | hbit_rise;
      status_d[`IRQ_HALTED_BIT] = status_d[`IRQ_HALTED_BIT] | halt_event;
      status_d[`IRQ_RESUMED_BIT] = status_d[`IRQ_RESUMED_BIT] | resume_event;
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= {`ADDR_W{1'b0}};
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         polarity_q <= `REG16_RESET;
         suspend_q <= `REG16_RESET;
         enable_q <= `REG16_RESET;
         mask_q <= `IRQ_RESET;
         status_q <= `IRQ_RESET;
      end else begin
         status_q <= status_d;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            // reserved bits are held at zero whatever software writes
            case (awaddr_q)
               `OFS_STROBE_IRQ_POLARITY: begin
                  polarity_q <= wr_bits[15:0] & `POL_WR_MASK;
               end
               `OFS_SUSPEND_MANAGEMENT: begin
                  suspend_q <= wr_bits[15:0] & `SUS_WR_MASK;
               end
               `OFS_STROBE_IRQ_ENABLE: begin
                  enable_q <= wr_bits[15:0] & `POL_WR_MASK;
               end
               `OFS_IRQ_MASK: begin
                  mask_q <= wr_bits[`IRQ_W-1:0];
               end
               default: begin
               end
            endcase
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ---- axi4-lite read side
   assign s_axi_arready = ~rvalid_q;
   assign rd_fire = s_axi_arvalid & ~rvalid_q;

   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `OFS_STROBE_IRQ_POLARITY: rd_word[15:0] = polarity_q;
         `OFS_SUSPEND_MANAGEMENT: rd_word[15:0] = suspend_q;
         `OFS_STROBE_IRQ_ENABLE: rd_word[15:0] = enable_q;
         `OFS_IRQ_STATUS: rd_word[`IRQ_W-1:0] = status_q;
         `OFS_IRQ_MASK: rd_word[`IRQ_W-1:0] = mask_q;
         `OFS_PORT_STATUS: begin
            rd_word[`PST_HALTED_BIT] = dma_halt;
            rd_word[`PST_READY_BIT] = ready_flag_q;
            rd_word[`PST_STROBE_BIT] = ready_pin_s & strobe_s;
            rd_word[`PST_SUSPEND_BIT] = suspend_s;
            rd_word[`PST_MUX8_BIT] = mux8_mode;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign irq = |(status_q & mask_q);
endmodule // host_port_suspend_irq_ctrl

/* File: rtl/suspend_ctrl.v */
// emulation suspend policy: run free or soft stop after current transfers
`include "host_port_ctrl_regs.vh"
module suspend_ctrl (
   // clock and reset
   input wire clock,
   input wire rstn,
   // policy bits
   input wire ignore_suspend,
   input wire graceful_halt,
   // suspend request and activity
   input wire suspend_req,
   input wire host_busy,
   input wire dma_busy,
   // results
   output wire dma_halt,
   output wire halt_event,
   output wire resume_event
);
   reg halted_q;
   wire stop_wanted;
   wire idle;

   assign stop_wanted = suspend_req & ~ignore_suspend & graceful_halt;
   assign idle = ~host_busy & ~dma_busy;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         halted_q <= 1'b0;
      end else if (!halted_q) begin
         // halt only once nothing is in flight so no transfer is cut in half
         if (stop_wanted && idle) begin
            halted_q <= 1'b1;
         end
      end else if (!stop_wanted) begin
         halted_q <= 1'b0;
      end
   end

   assign dma_halt = halted_q;
   assign halt_event = ~halted_q & stop_wanted & idle;
   assign resume_event = halted_q & ~stop_wanted;
endmodule // suspend_ctrl

/* File: rtl/sync2.v */
// two-flop synchroniser for a single level from outside the clock domain
module sync2 (
   // clock and reset
   input wire clock,
   input wire rstn,
   // level in and out
   input wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // sync2

/* File: testbench/host_port_suspend_irq_ctrl_properties.sv */
// assertion checker for the host port control block
module host_port_props (
   // clock and reset
   input logic clock,
   input logic rstn,
   // bus handshakes
   input logic s_axi_awready,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata,
   // port side
   input logic host_to_cpu_irq_bit,
   input logic write_fifo_room,
   input logic emu_suspend,
   input logic host_busy,
   input logic dma_busy,
   input logic cpu_irq_req,
   input logic dma_halt,
   input logic host_ready_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   req_pulse_a: assert property (cpu_irq_req |=> !cpu_irq_req)
      else $error("cpu request longer than one cycle");
   host_req_a: assert property ($rose(host_to_cpu_irq_bit) |-> ##[1:6] cpu_irq_req)
      else $error("host interrupt bit gave no cpu request");
   flag_high_a: assert property (write_fifo_room [*5] |-> host_ready_flag)
      else $error("ready flag low with fifo room");
   flag_low_a: assert property (!write_fifo_room [*5] |-> !host_ready_flag)
      else $error("ready flag high without fifo room");
   halt_idle_a: assert property ($rose(dma_halt) |->
      !$past(host_busy) && !$past(dma_busy)) else $error("halt while transfers busy");
   resume_a: assert property (!emu_suspend [*5] |-> !dma_halt)
      else $error("halt held without suspend");
endmodule // host_port_props

bind host_port_suspend_irq_ctrl host_port_props u_props (.clock(clock), .rstn(rstn),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .host_to_cpu_irq_bit(host_to_cpu_irq_bit), .write_fifo_room(write_fifo_room),
   .emu_suspend(emu_suspend), .host_busy(host_busy), .dma_busy(dma_busy),
   .cpu_irq_req(cpu_irq_req), .dma_halt(dma_halt), .host_ready_flag(host_ready_flag));

/* File: testbench/host_port_suspend_irq_ctrl_tb.sv */
// self-checking bench for the host port control block
`include "host_port_ctrl_regs.vh"
module host_port_suspend_irq_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_t;
   logic clock, rstn, awvalid, wvalid, bready, arvalid, rready, mux8, emu, hbusy, dbusy;
   logic awready, wready, bvalid, arready, rvalid, irq_req, halt, flag, irq;
   logic s_act, s_inv, h_irq, room, strobe_n, irq_bit, fifo_room, rdy_pin;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, q;
   logic [1:0] bresp, rresp, r;
   int fail_count = 0, n_tests = 0, cyc = 0, k, c;
   // suspend settings that must leave the port running: ignore, ignore with graceful, run free
   logic [31:0] free_cfg [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0000};
   row_t rows [5] = '{'{8'h00, 32'hFFFF_FFFF, 32'h0000_0004, `RESP_OKAY},
      '{8'h04, 32'hFFFF_FFFF, 32'h0000_0003, `RESP_OKAY},
      '{8'h40, 32'h0000_0001, 32'h0000_0000, `RESP_SLVERR},
      '{8'h00, 32'h0000_0000, 32'h0000_0000, `RESP_OKAY},
      '{8'h04, 32'h0000_0000, 32'h0000_0000, `RESP_OKAY}};
   host_port_suspend_irq_ctrl uut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .strobe_pin_n(strobe_n), .mux8_mode(mux8), .host_to_cpu_irq_bit(irq_bit),
      .write_fifo_room(fifo_room), .ready_pin(rdy_pin), .emu_suspend(emu),
      .host_busy(hbusy), .dma_busy(dbusy), .cpu_irq_req(irq_req), .dma_halt(halt),
      .host_ready_flag(flag), .irq(irq));
   host_side_model host (.clock(clock), .s_act(s_act), .s_inv(s_inv), .h_irq(h_irq),
      .room(room), .strobe_pin_n(strobe_n), .host_to_cpu_irq_bit(irq_bit),
      .write_fifo_room(fifo_room), .ready_pin(rdy_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic cnt(input int n);
      c = 0;
      repeat (n) begin
         @(posedge clock);
         if (irq_req === 1'b1) c++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      // whole run needs well under two thousand cycles
      if (cyc == 20000) begin
         fail_count++;
         final_report;
      end
   end
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, emu, hbusy, dbusy} = '0;
      {s_act, s_inv, h_irq, room, awaddr, araddr, wdata} = '0;
      mux8 = 1'b1;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h00, q, r); chk(q, 32'h0);
      rd(8'h04, q, r); chk(q, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r); chk(r, rows[i].r);
         rd(rows[i].a, q, r); chk(q, rows[i].q);
         chk(r, rows[i].r);
      end
      wr(8'h08, 32'h0000_0004, r);
      for (k = 0; k < 2; k++) begin
         wr(8'h00, {29'h0, k[0], 2'h0}, r);
         s_inv <= k[0];
         s_act <= 1'b0;
         cnt(8);
         s_act <= 1'b1;
         cnt(12); chk(c, 1);
      end
      s_act <= 1'b0;
      mux8 <= 1'b0;
      cnt(8);
      s_act <= 1'b1;
      cnt(12); chk(c, 0);
      wr(8'h0C, 32'h0000_0007, r);
      h_irq <= 1'b1;
      cnt(10); chk(c, 1);
      chk(irq, 1'b0);
      wr(8'h10, 32'h0000_0001, r); chk(irq, 1'b1);
      wr(8'h0C, 32'h0000_0001, r); chk(irq, 1'b0);
      rd(8'h0C, q, r); chk(q, 32'h0);
      foreach (free_cfg[i]) begin
         wr(8'h04, free_cfg[i], r);
         emu <= 1'b1;
         cnt(10); chk(halt, 1'b0);
         emu <= 1'b0;
         cnt(5);
      end
      wr(8'h04, 32'h0000_0002, r);
      hbusy <= 1'b1;
      emu <= 1'b1;
      cnt(10); chk(halt, 1'b0);
      {hbusy, dbusy} <= 2'b01;
      cnt(5); chk(halt, 1'b0);
      dbusy <= 1'b0;
      cnt(5); chk(halt, 1'b1);
      emu <= 1'b0;
      cnt(5); chk(halt, 1'b0);
      rd(8'h0C, q, r); chk(q, 32'h6);
      room <= 1'b1;
      cnt(6); chk(flag, 1'b1);
      room <= 1'b0;
      cnt(6); chk(flag, 1'b0);
      final_report;
   end
endmodule // host_port_suspend_irq_ctrl_tb

/* File: testbench/host_side_model.sv */
// far-side host model: strobe pin, host interrupt bit, fifo room and ready pin
module host_side_model (
   // clock
   input logic clock,
   // requests from the bench
   input logic s_act,
   input logic s_inv,
   input logic h_irq,
   input logic room,
   // host pins
   output logic strobe_pin_n = 1'b1,
   output logic host_to_cpu_irq_bit = 1'b0,
   output logic write_fifo_room = 1'b0,
   output logic ready_pin = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clock) begin
      strobe_pin_n <= s_act ? s_inv : !s_inv;
      host_to_cpu_irq_bit <= h_irq;
      write_fifo_room <= room;
      // pin kept opposite to fifo room so a flag copied from the pin shows up
      ready_pin <= !room;
   end
endmodule // host_side_model
